// *** pcsic_pkg.sv ***
// constants, address map and types shared by the program-flow core and its stack
// assumes a single core clock and an 8-bit register port with bank select in address bit 7
package pcsic_pkg;

	// widths
	localparam int PC_W        = 13;
	localparam int LIT_W       = 11;
	localparam int LATCH_W     = 5;
	localparam int DATA_W      = 8;
	localparam int ADDR_W      = 8;
	localparam int EFF_W       = 9;
	localparam int STACK_DEPTH = 8;
	localparam int STACK_PTR_W = 3;
	localparam int RAM_DEPTH   = 80;
	localparam int RAM_IDX_W   = 7;

	// register offsets, low seven bits decoded so they appear in both banks
	localparam logic [6:0] ADR_WINDOW  = 7'h00;
	localparam logic [6:0] ADR_PCL     = 7'h02;
	localparam logic [6:0] ADR_STATUS  = 7'h03;
	localparam logic [6:0] ADR_POINTER = 7'h04;
	localparam logic [6:0] ADR_LATCH   = 7'h0a;
	localparam logic [6:0] ADR_INTERRUPT_CONTROL  = 7'h0b;
	// bank 1 only
	localparam logic [7:0] ADR_CAUSE   = 8'h8e;
	// general-purpose data, bank 0 only
	localparam logic [7:0] RAM_BASE    = 8'h20;
	localparam logic [7:0] RAM_LAST    = 8'h6f;
	localparam int         BANK_BIT    = 7;

	// interrupt_control field positions
	localparam int IC_GIE     = 7;
	localparam int IC_RSVD    = 6;
	localparam int IC_T0_EN   = 5;
	localparam int IC_EXT_EN  = 4;
	localparam int IC_PORT_EN = 3;
	localparam int IC_T0_FL   = 2;
	localparam int IC_EXT_FL  = 1;
	localparam int IC_PORT_FL = 0;
	localparam logic [7:0] IC_WR_MASK = 8'hbf;
	localparam logic [7:0] IC_RESET   = 8'h00;

	// reset_cause field positions
	localparam int RC_POR = 1;
	localparam int RC_WDT = 0;
	localparam logic [7:0] RC_WR_MASK = 8'h03;
	localparam logic [1:0] RC_SETTLE  = 2'h3;

	// status field kept here
	localparam int ST_BANK = 7;

	localparam logic [PC_W-1:0] PC_RESET   = 13'h0000;
	localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
	localparam logic [PC_W-1:0] PC_ONE     = 13'h0001;

	typedef enum {
		PCSIC_T_NONE, PCSIC_T_WINDOW, PCSIC_T_PCL, PCSIC_T_STATUS,
		PCSIC_T_POINTER, PCSIC_T_LATCH, PCSIC_T_INTERRUPT_CONTROL, PCSIC_T_CAUSE, PCSIC_T_RAM
	} pcsic_target_t;

endpackage

// *** pcsic_stack.sv ***
// circular return stack, eight entries of program counter width
// push wins when push and pop come in the same cycle; the core gives the vector priority
`timescale 1ns/1ps
module pcsic_stack (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        push,
	input  wire logic                        pop,
	input  wire logic [pcsic_pkg::PC_W-1:0]  push_data,
	output logic      [pcsic_pkg::PC_W-1:0]  top
);
	import pcsic_pkg::*;

	typedef struct packed {
		logic [STACK_DEPTH-1:0][PC_W-1:0] entry;
		logic [STACK_PTR_W-1:0]           ptr;
	} pcsic_stack_st_t;

	pcsic_stack_st_t st_r;
	pcsic_stack_st_t st_nxt;
	logic [STACK_PTR_W-1:0] below;

	// entry just under the pointer is the newest one
	assign below = st_r.ptr - 3'h1;
	assign top   = st_r.entry[below];

	// pointer wraps in both directions, no overflow or underflow flag exists
	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.entry[st_r.ptr] = push_data;
			st_nxt.ptr             = st_r.ptr + 3'h1;
		end else if (pop) begin
			st_nxt.ptr = below;
		end
	end

	// reset clears every entry as well as the pointer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule

// *** pcsic_core.sv ***
// program counter, return stack, indirect addressing, interrupt control and reset cause
// assumes the execution logic issues one flow operation per cycle and drives the register port
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module pcsic_core (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// register port
	input  wire logic [pcsic_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [pcsic_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [pcsic_pkg::DATA_W-1:0]  reg_rdata,
	// flow operations from the execution logic
	input  wire logic                          op_advance,
	input  wire logic                          op_call,
	input  wire logic                          op_jump,
	input  wire logic                          op_return,
	input  wire logic                          op_return_with_literal,
	input  wire logic                          op_return_from_interrupt,
	input  wire logic                          op_irq_vector,
	input  wire logic [pcsic_pkg::LIT_W-1:0]   lit_addr,
	// interrupt source events, one-cycle pulses on the core clock
	input  wire logic                          timer_overflow_evt,
	input  wire logic                          external_edge_evt,
	input  wire logic                          port_change_evt,
	// reset kind levels from the reset controller, asynchronous
	input  wire logic                          cause_power_on,
	input  wire logic                          cause_watchdog_timer,
	output logic      [pcsic_pkg::PC_W-1:0]    pc,
	output logic                               irq_request
);
	import pcsic_pkg::*;

	typedef struct packed {
		logic [PC_W-1:0]                 pc;
		logic [LATCH_W-1:0]              pc_high_latch;
		logic [DATA_W-1:0]               pointer_register;
		logic                            indirect_bank_bit;
		logic [DATA_W-1:0]               interrupt_control;
		logic [DATA_W-1:0]               reset_cause;
		logic [1:0]                      por_sync;
		logic [1:0]                      wdt_sync;
		logic [1:0]                      settle_cnt;
		logic                            cause_taken;
		logic [DATA_W-1:0]               rdata;
		logic                            irq_req;
		logic [RAM_DEPTH-1:0][DATA_W-1:0] ram;
	} pcsic_core_st_t;

	pcsic_core_st_t      st_r;
	pcsic_core_st_t      st_nxt;
	logic [EFF_W-1:0]    eff_addr;
	logic [ADDR_W-1:0]   acc_addr;
	pcsic_target_t       acc_target;
	logic                via_window;
	logic [RAM_IDX_W-1:0] ram_idx;
	logic                stack_push;
	logic                stack_pop;
	logic [PC_W-1:0]     stack_top;
	logic [DATA_W-1:0]   rd_value;
	logic [2:0]          events;
	logic [2:0]          pending;

	// map a bank-qualified address onto the register it selects
	function automatic pcsic_target_t decode(input logic [ADDR_W-1:0] a);
		pcsic_target_t t;
		t = PCSIC_T_NONE;
		if (a == ADR_CAUSE) begin
			t = PCSIC_T_CAUSE;
		end else if (!a[BANK_BIT] && a >= RAM_BASE && a <= RAM_LAST) begin
			t = PCSIC_T_RAM;
		end else begin
			unique case (a[6:0])
				ADR_WINDOW:  t = PCSIC_T_WINDOW;
				ADR_PCL:     t = PCSIC_T_PCL;
				ADR_STATUS:  t = PCSIC_T_STATUS;
				ADR_POINTER: t = PCSIC_T_POINTER;
				ADR_LATCH:   t = PCSIC_T_LATCH;
				ADR_INTERRUPT_CONTROL:  t = PCSIC_T_INTERRUPT_CONTROL;
				default:     t = PCSIC_T_NONE;
			endcase
		end
		return t;
	endfunction

	// the window is redirected through the pointer; the bank bit sits above it
	always_comb begin
		eff_addr   = {st_r.indirect_bank_bit, st_r.pointer_register};
		via_window = (decode(reg_addr) == PCSIC_T_WINDOW);
		// the ninth address bit is unused on this part, so only the low byte is decoded
		acc_addr   = via_window ? eff_addr[ADDR_W-1:0] : reg_addr;
		acc_target = decode(acc_addr);
		ram_idx    = RAM_IDX_W'(acc_addr - RAM_BASE);
	end

	// read mux; the stack has no address and cannot be reached here
	always_comb begin
		rd_value = '0;
		unique case (acc_target)
			PCSIC_T_WINDOW:  rd_value = '0;
			PCSIC_T_PCL:     rd_value = st_r.pc[DATA_W-1:0];
			PCSIC_T_STATUS:  rd_value = {st_r.indirect_bank_bit, 7'h00};
			PCSIC_T_POINTER: rd_value = st_r.pointer_register;
			PCSIC_T_LATCH:   rd_value = {3'h0, st_r.pc_high_latch};
			PCSIC_T_INTERRUPT_CONTROL:  rd_value = st_r.interrupt_control;
			PCSIC_T_CAUSE:   rd_value = st_r.reset_cause;
			PCSIC_T_RAM:     rd_value = st_r.ram[ram_idx];
			PCSIC_T_NONE:    rd_value = '0;
		endcase
	end

	// vector wins over every other flow operation and blocks the pop; a call with a return only pushes, as the stack gives the push priority
	assign stack_push = op_irq_vector || op_call;
	assign stack_pop  = !op_irq_vector &&
	                    (op_return || op_return_with_literal || op_return_from_interrupt);

	assign events  = {timer_overflow_evt, external_edge_evt, port_change_evt};
	assign pending = st_r.interrupt_control[IC_T0_EN:IC_PORT_EN] &
	                 st_r.interrupt_control[IC_T0_FL:IC_PORT_FL];

	// next-state of the whole core
	always_comb begin
		st_nxt = st_r;

		// register writes
		if (reg_wr) begin
			unique case (acc_target)
				PCSIC_T_WINDOW:  ;
				PCSIC_T_PCL:     ;
				PCSIC_T_STATUS:  st_nxt.indirect_bank_bit = reg_wdata[ST_BANK];
				PCSIC_T_POINTER: st_nxt.pointer_register = reg_wdata;
				PCSIC_T_LATCH:   st_nxt.pc_high_latch = reg_wdata[LATCH_W-1:0];
				PCSIC_T_INTERRUPT_CONTROL:  st_nxt.interrupt_control = reg_wdata & IC_WR_MASK;
				PCSIC_T_CAUSE:   st_nxt.reset_cause = reg_wdata & RC_WR_MASK;
				PCSIC_T_RAM:     st_nxt.ram[ram_idx] = reg_wdata;
				PCSIC_T_NONE:    ;
			endcase
		end

		// hardware sets flags after the software write so a same-cycle event is not lost
		st_nxt.interrupt_control[IC_T0_FL:IC_PORT_FL] =
			st_nxt.interrupt_control[IC_T0_FL:IC_PORT_FL] | events;

		// program counter; the stack and its pointer never touch the latch
		if (op_irq_vector) begin
			st_nxt.pc = IRQ_VECTOR;
			// masking re-entry until the interrupt return
			st_nxt.interrupt_control[IC_GIE] = 1'b0;
		end else if (op_call || op_jump) begin
			st_nxt.pc = {st_r.pc_high_latch[LATCH_W-1:LATCH_W-2], lit_addr};
		end else if (stack_pop) begin
			st_nxt.pc = stack_top;
			if (op_return_from_interrupt) begin
				st_nxt.interrupt_control[IC_GIE] = 1'b1;
			end
		end else if (reg_wr && acc_target == PCSIC_T_PCL) begin
			// only the written byte lands low, so no carry can reach the upper bits
			st_nxt.pc = {st_r.pc_high_latch, reg_wdata};
		end else if (op_advance) begin
			st_nxt.pc = st_r.pc + PC_ONE;
		end

		// request asks the execution logic for a vector
		st_nxt.irq_req = st_r.interrupt_control[IC_GIE] && (|pending);

		// two-stage synchronisers for the reset kind levels
		st_nxt.por_sync = {st_r.por_sync[0], cause_power_on};
		st_nxt.wdt_sync = {st_r.wdt_sync[0], cause_watchdog_timer};

		// reset kind is taken once the synchronisers have settled after release
		if (!st_r.cause_taken) begin
			if (st_r.settle_cnt == RC_SETTLE) begin
				st_nxt.cause_taken          = 1'b1;
				// capture overrides a software write in the same cycle
				st_nxt.reset_cause[RC_POR]  = st_r.por_sync[1];
				st_nxt.reset_cause[RC_WDT]  = st_r.wdt_sync[1];
			end else begin
				st_nxt.settle_cnt = st_r.settle_cnt + 2'h1;
			end
		end

		// read data stands one cycle after the strobe, zero otherwise
		st_nxt.rdata = reg_rd ? rd_value : '0;
	end

	// every reset clears the counter and all control state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r                   <= '0;
			st_r.pc                <= PC_RESET;
			st_r.interrupt_control <= IC_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// return stack lives outside program and data space
	pcsic_stack u_stack (
		.clk       (clk),
		.nrst      (nrst),
		.push      (stack_push),
		.pop       (stack_pop),
		.push_data (st_r.pc),
		.top       (stack_top)
	);

	// outputs straight from the state register
	assign pc          = st_r.pc;
	assign reg_rdata   = st_r.rdata;
	assign irq_request = st_r.irq_req;

endmodule

// *** pcsic_props.sv ***
// assertions on the program-flow core ports
// assumes one core clock and an active-low asynchronous reset
`timescale 1ns/1ps
module pcsic_props (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        op_advance,
	input wire logic        op_call,
	input wire logic        op_jump,
	input wire logic        op_return,
	input wire logic        op_return_with_literal,
	input wire logic        op_return_from_interrupt,
	input wire logic        op_irq_vector,
	input wire logic [10:0] lit_addr,
	input wire logic [12:0] pc
);
	logic [4:0] lat_r;
	logic [1:0] lat_top;
	logic       pop;
	logic       flow;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// latch shadow, direct writes only; window writes to it are not tracked
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			lat_r <= 5'h00;
		else if (reg_wr && reg_addr[6:0] == 7'h0a)
			lat_r <= reg_wdata[4:0];
	end
	// flow grouping
	assign lat_top = lat_r[4:3];
	assign pop     = op_return | op_return_with_literal | op_return_from_interrupt;
	assign flow    = op_irq_vector | op_call | op_jump | pop;
	chk_reset_pc: assert property ($rose(nrst) |-> pc == 13'h0000)
		else $error("pc not zero after reset");
	chk_adv_inc: assert property (op_advance && !flow && !reg_wr |=> pc == $past(pc) + 13'h0001)
		else $error("advance did not add one");
	chk_pcl_load: assert property (reg_wr && reg_addr[6:0] == 7'h02 && !flow
		|=> pc == {$past(lat_r), $past(reg_wdata)}) else $error("low byte write load wrong");
	chk_lit_low: assert property ((op_call | op_jump) && !op_irq_vector |=> pc[10:0] == $past(lit_addr))
		else $error("literal bits not loaded");
	chk_top_bits: assert property ((op_call | op_jump) && !op_irq_vector |=> pc[12:11] == $past(lat_top))
		else $error("top bits not from latch");
	chk_vector_pc: assert property (op_irq_vector |=> pc == 13'h0004)
		else $error("vector address wrong");
	chk_call_ret: assert property ((op_call && !op_irq_vector) ##1 (pop && !op_irq_vector && !op_call && !op_jump)
		|=> pc == $past(pc, 2)) else $error("return did not restore pc");
	chk_rsvd_zero: assert property (reg_rd && reg_addr[6:0] == 7'h0b |=> reg_rdata[6] == 1'b0)
		else $error("reserved bit reads one");
	cover property (op_call ##1 pop);
	cover property (op_irq_vector);
	cover property (reg_rd && reg_addr == 8'h00);
endmodule
bind pcsic_core pcsic_props pcsic_props_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.op_advance(op_advance), .op_call(op_call), .op_jump(op_jump), .op_return(op_return),
	.op_return_with_literal(op_return_with_literal), .op_return_from_interrupt(op_return_from_interrupt),
	.op_irq_vector(op_irq_vector), .lit_addr(lit_addr), .pc(pc));

// *** pcsic_exec.sv ***
// stand-in for the execution logic: a command code becomes flow pulses
// assumes the code changes just after a rising edge
`timescale 1ns/1ps
module pcsic_exec (
	input  wire logic [2:0]  cmd,
	input  wire logic [10:0] lit_in,
	output logic             op_advance,
	output logic             op_call,
	output logic             op_jump,
	output logic             op_return,
	output logic             op_return_with_literal,
	output logic             op_return_from_interrupt,
	output logic             op_irq_vector,
	output logic [10:0]      lit_addr
);
	// decode; literal is garbage unless a call or jump is issued
	always_comb begin
		op_advance               = cmd == 3'h1;
		op_call                  = cmd == 3'h2;
		op_jump                  = cmd == 3'h3;
		op_return                = cmd == 3'h4;
		op_return_with_literal   = cmd == 3'h5;
		op_return_from_interrupt = cmd == 3'h6;
		op_irq_vector            = cmd == 3'h7;
		lit_addr                 = (op_call | op_jump) ? lit_in : ~lit_in;
	end
endmodule

// *** pc_stack_indirect_core_tb.sv ***
// self-checking bench for the program-flow core
// assumes a 100 MHz clock and the stand-in execution model
`timescale 1ns/1ps
module pc_stack_indirect_core_tb;
	logic        clk, nrst, reg_wr, reg_rd, t_evt, e_evt, p_evt, por, wdt, irq;
	logic        adv, call, jmp, ret, retl, reti, vec;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
	logic [2:0]  cmd;
	logic [10:0] lit, lit_addr;
	logic [12:0] pc;
	int          miscompares, total_checks, k;
	// write addr, write data, read addr, expected read
	logic [31:0] rows [8] = '{32'h0bff0bbf, 32'h8b380b38, 32'h0aff0a1f, 32'h04250425,
		32'h255a005a, 32'h7f117f00, 32'h0a030a03, 32'h83ff0380};
	pcsic_core pcsic_core_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_advance(adv), .op_call(call),
		.op_jump(jmp), .op_return(ret), .op_return_with_literal(retl), .op_return_from_interrupt(reti),
		.op_irq_vector(vec), .lit_addr(lit_addr), .timer_overflow_evt(t_evt), .external_edge_evt(e_evt),
		.port_change_evt(p_evt), .cause_power_on(por), .cause_watchdog_timer(wdt), .pc(pc),
		.irq_request(irq));
	pcsic_exec pcsic_exec_inst (.cmd(cmd), .lit_in(lit), .op_advance(adv), .op_call(call), .op_jump(jmp),
		.op_return(ret), .op_return_with_literal(retl), .op_return_from_interrupt(reti),
		.op_irq_vector(vec), .lit_addr(lit_addr));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		#1;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// code stays up until the next call, so ops can run back to back
	task automatic op(input logic [2:0] c, input logic [10:0] l);
		@(posedge clk);
		cmd <= c;
		lit <= l;
		#1;
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		close_out();
	end
	// main sequence
	initial begin
		{nrst, reg_wr, reg_rd, t_evt, e_evt, p_evt, wdt} = 7'h00;
		por = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		cmd = 3'h0;
		lit = 11'h000;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk("pc", pc, 13'h0000);
		rd(8'h8e);
		chk("cause", rv, 8'h02);
		$display("reset done");
		for (k = 0; k < 8; k++) begin
			wr(rows[k][31:24], rows[k][23:16]);
			rd(rows[k][15:8]);
			chk("reg", rv, rows[k][7:0]);
		end
		$display("table done");
		wr(8'h0a, 8'h13);
		wr(8'h02, 8'h40);
		chk("pc", pc, 13'h1340);
		rd(8'h02);
		chk("pcl", rv, 8'h40);
		wr(8'h0a, 8'h1f);
		wr(8'h02, 8'hff);
		op(3'h1, 11'h000);
		op(3'h0, 11'h000);
		chk("pc", pc, 13'h0000);
		wr(8'h0a, 8'h18);
		op(3'h3, 11'h123);
		op(3'h0, 11'h000);
		chk("pc", pc, 13'h1923);
		wr(8'h0a, 8'h03);
		$display("counter done");
		// nine calls overrun eight entries, pops cycle through all three kinds
		op(3'h3, 11'h000);
		for (k = 1; k < 10; k++)
			op(3'h2, 11'(k));
		for (k = 0; k < 9; k++) begin
			op(3'(4 + k % 3), 11'h000);
			op(3'h0, 11'h000);
			chk("pop", pc, k == 8 ? 16'h8 : 16'(8 - k));
		end
		op(3'h2, 11'h155);
		op(3'h4, 11'h000);
		op(3'h0, 11'h000);
		chk("ret", pc, 13'h0008);
		op(3'h7, 11'h000);
		op(3'h0, 11'h000);
		chk("vec", pc, 13'h0004);
		op(3'h6, 11'h000);
		op(3'h0, 11'h000);
		chk("reti", pc, 13'h0008);
		rd(8'h0a);
		chk("latch", rv, 8'h03);
		$display("stack done");
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h77);
		rd(8'h00);
		chk("self", rv, 8'h00);
		wr(8'h0b, 8'h00);
		@(posedge clk);
		{t_evt, e_evt, p_evt} <= 3'h7;
		@(posedge clk);
		{t_evt, e_evt, p_evt} <= 3'h0;
		rd(8'h0b);
		chk("flags", rv, 8'h07);
		chk("irq", irq, 1'b0);
		wr(8'h0b, 8'ha4);
		repeat (2) @(posedge clk);
		#1 chk("irq", irq, 1'b1);
		wr(8'h0b, 8'h24);
		repeat (2) @(posedge clk);
		#1 chk("irq", irq, 1'b0);
		$display("window and flags done");
		@(posedge clk);
		nrst <= 1'b0;
		por <= 1'b0;
		wdt <= 1'b1;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		#1 chk("pc", pc, 13'h0000);
		repeat (6) @(posedge clk);
		rd(8'h8e);
		chk("cause", rv, 8'h01);
		$display("second reset done");
		close_out();
	end
endmodule
